// ===== dv/alarm_conditioner_properties.sv
`default_nettype none
module alarm_conditioner_properties
	import alarm_avg_pkg::*;
#(
	parameter int TICK_CYC = 10
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire sample_s sample_in,
	input wire logic ext_reset_in,
	input wire logic btn_down_in,
	input wire logic btn_up_in,
	input wire latch_mode_e latch_mode_param_in,
	input wire logic [13:0] powerup_alarm_delay_param_in,
	input wire logic overrange_action_param_in,
	input wire alarms_s alarm_out,
	input wire alarms_s indicator_out,
	input wire logic [SAMPLE_W-1:0] display_out,
	input wire logic display_frozen_out,
	input wire menu_e menu_out,
	input wire logic [13:0] delay_edit_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned cyc_r;
	int unsigned ovr_r;
	logic [13:0] dly_r;
	// Delay taken once after release, later edits must not count
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cyc_r <= 0;
			ovr_r <= 0;
			dly_r <= 14'h0000;
		end else begin
			cyc_r <= (cyc_r < 32'h00FFFFFF) ? cyc_r + 1 : cyc_r;
			ovr_r <= (sample_in.overrange && !overrange_action_param_in) ? ovr_r + 1 : 0;
			dly_r <= (cyc_r == 0) ? powerup_alarm_delay_param_in : dly_r;
		end
	end
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////
	delay_quiet_a:
		assert property (cyc_r > 0 && cyc_r < DELAY_TICKS_PER_TENTH * dly_r * TICK_CYC |-> alarm_out == '0)
		else $error("alarm during power-on delay");
	overrange_off_a:
		assert property (ovr_r > 0 |-> alarm_out == '0 && indicator_out == '0)
		else $error("alarm during disabled over-range");
	frozen_hold_a:
		assert property (display_frozen_out [*2] |-> $stable(display_out))
		else $error("display moved while frozen");
	no_latch_a:
		assert property (latch_mode_param_in == LATCH_NONE [*3] |-> !display_frozen_out)
		else $error("frozen without latch mode");
	reset_clear_a:
		assert property (ext_reset_in [*3] |-> !display_frozen_out)
		else $error("frozen under reset input");
	menu_entry_a:
		assert property (menu_out == MENU_AVG_TYPE && $past(menu_out) == MENU_MEASURE |-> $past(btn_down_in && btn_up_in))
		else $error("menu entered without both buttons");
	menu_step_a:
		assert property (menu_out != $past(menu_out) && menu_out != MENU_MEASURE && $past(menu_out) != MENU_MEASURE
			|-> $past(btn_down_in || btn_up_in) || $past(btn_down_in || btn_up_in, 2) || $past(btn_down_in || btn_up_in, 3))
		else $error("menu moved without button");
	delay_range_a:
		assert property (delay_edit_out <= DELAY_MAX)
		else $error("delay edit above range");
endmodule
bind alarm_conditioner alarm_conditioner_properties #(.TICK_CYC(TICK_CYC)) props_u (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sample_in(sample_in), .ext_reset_in(ext_reset_in),
	.btn_down_in(btn_down_in), .btn_up_in(btn_up_in), .latch_mode_param_in(latch_mode_param_in),
	.powerup_alarm_delay_param_in(powerup_alarm_delay_param_in),
	.overrange_action_param_in(overrange_action_param_in), .alarm_out(alarm_out),
	.indicator_out(indicator_out), .display_out(display_out), .display_frozen_out(display_frozen_out),
	.menu_out(menu_out), .delay_edit_out(delay_edit_out)
);
`default_nettype wire

// ===== dv/alarm_conditioner_tb.sv
`default_nettype none
module alarm_conditioner_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import alarm_avg_pkg::*;
	localparam int TC = 10;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ext_rst = 1'b0;
	logic bdn = 1'b0;
	logic bup = 1'b0;
	logic sft = 1'b0;
	logic dup = 1'b0;
	logic [1:0] edig;
	logic [13:0] dedit;
	logic [SAMPLE_W-1:0] lvl = 24'hFFFFF6;
	logic ovr = 1'b0;
	logic hi = 1'b0;
	latch_mode_e lmode = LATCH_NONE;
	logic [13:0] dly = 14'h0003;
	logic hold = 1'b0;
	logic oact = 1'b1;
	avg_method_e meth = AVG_MOVING;
	logic [3:0] dep = 4'h0;
	setpoints_s sp = '{sp_ll: 24'hFFFC18, sp_l: 24'h000000, sp_h: 24'h0003E8, sp_hh: 24'h0007D0};
	sample_s smp;
	alarms_s alm, ind;
	logic [SAMPLE_W-1:0] disp, ana;
	logic aen, frz;
	menu_e menu;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int gap;
	sensor_model sensor_u (.mclk_in(mclk_in), .level_in(lvl), .ovr_in(ovr), .high_in(hi), .sample_out(smp));
	alarm_conditioner #(.TICK_CYC(TC)) dut_u (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sample_in(smp), .setpoints_in(sp), .ext_reset_in(ext_rst),
		.btn_down_in(bdn), .btn_up_in(bup), .btn_shift_in(sft), .digit_up_in(dup),
		.latch_mode_param_in(lmode), .powerup_alarm_delay_param_in(dly), .startup_hold_param_in(hold),
		.overrange_action_param_in(oact), .average_method_param_in(meth), .average_depth_param_in(dep),
		.alarm_out(alm), .indicator_out(ind), .display_out(disp), .analog_out(ana), .analog_enable_out(aen),
		.display_frozen_out(frz), .menu_out(menu), .edit_digit_out(edig), .delay_edit_out(dedit)
	);
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n * TC) @(negedge mclk_in);
	endtask
	task automatic do_reset();
		rst_n_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		rst_n_in = 1'b1;
	endtask
	task automatic wait_chg();
		logic [SAMPLE_W-1:0] old;
		old = disp;
		gap = 0;
		while (disp === old && gap < 4 * TC) begin
			@(negedge mclk_in);
			gap++;
		end
		chk(gap < 4 * TC, 1, "display never updated");
	endtask
	task automatic press(input logic dn);
		bdn = dn;
		bup = !dn;
		repeat (2) @(negedge mclk_in);
		bdn = 1'b0;
		bup = 1'b0;
		repeat (4) @(negedge mclk_in);
	endtask
	task automatic tap(input logic is_shift);
		sft = is_shift;
		dup = !is_shift;
		repeat (2) @(negedge mclk_in);
		sft = 1'b0;
		dup = 1'b0;
		repeat (2) @(negedge mclk_in);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_delay();
		do_reset();
		// Changed after the capture edge, so it must not count
		@(negedge mclk_in);
		dly = 14'h0000;
		ticks(4);
		chk(alm, 5'h00, "alarm inside delay");
		ticks(6);
		chk(alm, 5'h08, "low alarm after delay");
	endtask
	task automatic t_standby();
		hold = 1'b1;
		do_reset();
		@(negedge mclk_in);
		hold = 1'b0;
		ticks(4);
		chk({alm, aen}, 6'h00, "outputs held in standby");
		lvl = 24'h0001F4;
		ticks(3);
		chk({alm, aen}, 6'h03, "outputs live in pass zone");
		lvl = 24'hFFFFF6;
		ticks(3);
		chk(alm, 5'h08, "low alarm after standby");
	endtask
	task automatic t_latch();
		lmode = LATCH_OUT;
		lvl = 24'h0001F4;
		ticks(3);
		lvl = 24'hFFFFF6;
		ticks(3);
		lvl = 24'h0001F4;
		ticks(3);
		chk({alm, ind}, 10'h121, "low held, pass live");
		chk(disp, 24'h0001F4, "display runs on");
		ext_rst = 1'b1;
		ticks(1);
		ext_rst = 1'b0;
		ticks(2);
		chk(alm, 5'h01, "reset input clears");
		lmode = LATCH_ALL;
		lvl = 24'hFFFFF6;
		ticks(3);
		lvl = 24'h0001F4;
		ticks(3);
		chk({frz, alm}, 6'h28, "frozen with low held");
		chk(disp, 24'hFFFFF6, "display held");
		lmode = LATCH_NONE;
		ticks(3);
		chk({frz, alm}, 6'h01, "latch none releases");
	endtask
	task automatic t_ovr();
		ovr = 1'b1;
		for (int i = 0; i < 4; i++) begin
			hi = i[0];
			oact = !i[1];
			ticks(3);
			chk({alm, ind}, i[1] ? 10'h000 : (i[0] ? 10'h0C6 : 10'h318), "over-range");
		end
		ovr = 1'b0;
		oact = 1'b1;
		ticks(3);
	endtask
	task automatic t_avg();
		lvl = 24'h000064;
		ticks(3);
		dep = 4'h1;
		lvl = 24'h00012C;
		wait_chg();
		chk(disp, 24'h00012C, "restart takes only new samples");
		lvl = 24'h000064;
		wait_chg();
		chk(disp, 24'h0000C8, "sliding mean");
		chk(ana, 24'h0000C8, "analog takes mean");
		wait_chg();
		chk(gap, TC, "sliding refresh period");
		chk(disp, 24'h000064, "window full of new value");
		meth = AVG_BLOCK;
		lvl = 24'h0001F4;
		wait_chg();
		chk(disp, 24'h0001F4, "block mean");
		lvl = 24'h000384;
		wait_chg();
		chk(gap, TC * 2, "block period");
		chk(disp, 24'h000384, "block mean of group");
		dep = 4'h9;
		lvl = 24'h0000C8;
		ticks(511);
		chk(disp, 24'h000384, "512 block too early");
		ticks(3);
		chk(disp, 24'h0000C8, "512 block mean");
		meth = AVG_MOVING;
		dep = 4'h0;
		ticks(3);
	endtask
	task automatic t_edit();
		chk(edig, 2'h3, "edit starts fourth digit");
		chk(dedit, 14'h270F, "edit value clamped");
		tap(1'b0);
		chk(dedit, 14'h03E7, "top digit wraps");
		tap(1'b1);
		chk(edig, 2'h2, "shift to next digit");
		tap(1'b0);
		chk(dedit, 14'h0063, "digit wraps in range");
	endtask
	task automatic t_menu();
		menu_e exp_m [13] = '{MENU_PASS, MENU_LATCH, MENU_POWERUP_ALARM_DELAY_PARAM, MENU_STARTUP_HOLD_PARAM, MENU_OVR, MENU_ROUND,
			MENU_OVR, MENU_STARTUP_HOLD_PARAM, MENU_POWERUP_ALARM_DELAY_PARAM, MENU_LATCH, MENU_PASS, MENU_AVG_TYPE, MENU_MEASURE};
		dly = 14'h3FFF;
		bdn = 1'b1;
		bup = 1'b1;
		ticks(55);
		chk(menu, MENU_MEASURE, "menu too early");
		ticks(7);
		chk(menu, MENU_AVG_TYPE, "menu entry");
		bdn = 1'b0;
		bup = 1'b0;
		repeat (4) @(negedge mclk_in);
		for (int i = 0; i < 13; i++) begin
			press(i < 6);
			chk(menu, exp_m[i], "menu step");
			if (i == 2) begin
				t_edit();
			end
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		t_delay();
		t_standby();
		t_latch();
		t_ovr();
		t_avg();
		t_menu();
		wrap_up();
	end
endmodule
`default_nettype wire

// ===== dv/sensor_model.sv
`default_nettype none
module sensor_model
	import alarm_avg_pkg::*;
(
	input wire logic mclk_in,
	input wire logic [SAMPLE_W-1:0] level_in,
	input wire logic ovr_in,
	input wire logic high_in,
	output var sample_s sample_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// overflow direction travels with the over-range flag
	always_ff @(posedge mclk_in) begin
		sample_out <= '{overrange: ovr_in, over_high: high_in, value: level_in, valid: 1'b1};
	end
endmodule
`default_nettype wire

// ===== src/alarm_avg_pkg.sv
`default_nettype none
package alarm_avg_pkg;
	localparam int SAMPLE_W = 24;
	localparam int CLK_MHZ = 200;
	localparam int TICK_MS = 50;
	localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
	localparam int HOLD_S = 3;
	localparam int HOLD_TICKS = (HOLD_S * 1000) / TICK_MS;
	localparam int DELAY_TICKS_PER_TENTH = 2;
	localparam logic [13:0] DELAY_MAX = 14'h270F;
	localparam logic [13:0] DELAY_RESET = 14'h0000;
	localparam int DEPTH_MAX_LOG = 9;
	localparam int DEPTH_MAX = 512;
	localparam logic [3:0] DEPTH_RESET = 4'h0;
	typedef enum logic [1:0] {LATCH_NONE, LATCH_OUT, LATCH_ALL} latch_mode_e;
	typedef enum logic [0:0] {AVG_MOVING, AVG_BLOCK} avg_method_e;
	typedef enum logic [2:0] {MENU_MEASURE, MENU_AVG_TYPE, MENU_PASS, MENU_LATCH, MENU_POWERUP_ALARM_DELAY_PARAM, MENU_STARTUP_HOLD_PARAM,
		MENU_OVR, MENU_ROUND} menu_e;
	typedef struct packed {
		logic overrange;
		logic over_high;
		logic [SAMPLE_W-1:0] value;
		logic valid;
	} sample_s;
	typedef struct packed {
		logic [SAMPLE_W-1:0] sp_ll;
		logic [SAMPLE_W-1:0] sp_l;
		logic [SAMPLE_W-1:0] sp_h;
		logic [SAMPLE_W-1:0] sp_hh;
	} setpoints_s;
	typedef struct packed {
		logic ll;
		logic l;
		logic h;
		logic hh;
		logic pass;
	} alarms_s;
endpackage
`default_nettype wire

// ===== src/alarm_conditioner.sv
// Operation
// - Pass status and output never latch
// - Latch-all mode freezes display while latched
// - Latch mode: none, output, output plus freeze
// - Power-on delay 0.0 to 999.9 s
// - Alarms wait out power-on delay
// - Delay and standby apply after restart
// - Standby holds outputs until pass zone
// - Over-range trips high or low alarm
// - Over-range disabled forces all alarms off
// - Sliding or block mean, sliding default
// - Sliding mean restarts, averages gathered samples
// - Full window drops oldest sample
// - Sliding mode refreshes every sample period
// - Block mode averages complete groups
// - Depth off or 2 to 512
// - Averaged value drives analog output
// - Both buttons 3 s enter menu
// - Down and up step parameter order
// - Delay edit starts fourth digit, clamped
// - Latch cleared by none, restart, reset input
// - Alarms suppressed during power-on delay
`default_nettype none
module alarm_conditioner #(
	parameter int TICK_CYC = alarm_avg_pkg::TICK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire alarm_avg_pkg::sample_s sample_in,
	input wire alarm_avg_pkg::setpoints_s setpoints_in,
	input wire logic ext_reset_in,
	input wire logic btn_down_in,
	input wire logic btn_up_in,
	input wire logic btn_shift_in,
	input wire logic digit_up_in,
	input wire alarm_avg_pkg::latch_mode_e latch_mode_param_in,
	input wire logic [13:0] powerup_alarm_delay_param_in,
	input wire logic startup_hold_param_in,
	input wire logic overrange_action_param_in,
	input wire alarm_avg_pkg::avg_method_e average_method_param_in,
	input wire logic [3:0] average_depth_param_in,
	output alarm_avg_pkg::alarms_s alarm_out,
	output alarm_avg_pkg::alarms_s indicator_out,
	output logic [alarm_avg_pkg::SAMPLE_W-1:0] display_out,
	output logic [alarm_avg_pkg::SAMPLE_W-1:0] analog_out,
	output logic analog_enable_out,
	output logic display_frozen_out,
	output alarm_avg_pkg::menu_e menu_out,
	output logic [1:0] edit_digit_out,
	output logic [13:0] delay_edit_out
);
	import alarm_avg_pkg::*;
	localparam int TCW = $clog2(TICK_CYC + 1);
	localparam int DLW = 16;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [TCW-1:0] tick_cnt;
		logic tick;
		logic started;
		logic [13:0] delay_snap;
		logic hold_snap;
		logic [DLW-1:0] delay_ticks;
		logic [13:0] delay_tenths;
		logic delay_done;
		logic standby_done;
		avg_method_e method_seen;
		logic [3:0] depth_seen;
		alarms_s latched;
		alarms_s alarm;
		alarms_s indicator;
		logic [SAMPLE_W-1:0] display;
		logic [SAMPLE_W-1:0] analog;
		logic analog_en;
		logic frozen;
		logic [6:0] hold_cnt;
		logic down_q;
		logic up_q;
		logic shift_q;
		logic digit_q;
		menu_e menu;
		logic [1:0] digit;
		logic [13:0] delay_edit;
	} state_s;
	state_s st_r, st_nxt;

	logic restart;
	logic avg_done;
	logic [SAMPLE_W-1:0] avg_mean;
	alarms_s raw;
	logic any_latched;
	logic down_edge, up_edge, shift_edge, digit_edge;
	logic [3:0] dig_val;
	logic [13:0] step;

	function automatic logic [13:0] pow10(input logic [1:0] d);
		case (d)
			2'h0: pow10 = 14'h0001;
			2'h1: pow10 = 14'h000A;
			2'h2: pow10 = 14'h0064;
			default: pow10 = 14'h03E8;
		endcase
	endfunction

	// Same limit for the power-up copy and the edit copy
	function automatic logic [13:0] clamp_delay(input logic [13:0] v);
		clamp_delay = (v > DELAY_MAX) ? DELAY_MAX : v;
	endfunction

	assign restart = !st_r.started || (average_method_param_in != st_r.method_seen)
		|| (average_depth_param_in != st_r.depth_seen);

	avg_engine #(
		.W(SAMPLE_W),
		.DEPTH(DEPTH_MAX)
	) u_avg (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.restart_in(restart),
		.sample_in(st_r.tick && sample_in.valid && !sample_in.overrange && !st_r.frozen),
		.value_in(sample_in.value),
		.block_in(average_method_param_in == AVG_BLOCK),
		.depth_log_in(average_depth_param_in > 4'(DEPTH_MAX_LOG) ? 4'(DEPTH_MAX_LOG) : average_depth_param_in),
		.done_out(avg_done),
		.mean_out(avg_mean)
	);

	assign any_latched = |{st_r.latched.ll, st_r.latched.l, st_r.latched.h, st_r.latched.hh};
	assign down_edge = btn_down_in && !st_r.down_q;
	assign up_edge = btn_up_in && !st_r.up_q;
	assign shift_edge = btn_shift_in && !st_r.shift_q;
	assign digit_edge = digit_up_in && !st_r.digit_q;
	assign step = pow10(st_r.digit);
	assign dig_val = 4'((st_r.delay_edit / step) % 14'h000A);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		raw = '0;
		st_nxt.tick = 1'b0;
		st_nxt.down_q = btn_down_in;
		st_nxt.up_q = btn_up_in;
		st_nxt.shift_q = btn_shift_in;
		st_nxt.digit_q = digit_up_in;
		st_nxt.method_seen = average_method_param_in;
		st_nxt.depth_seen = average_depth_param_in;
		if (st_r.tick_cnt == TCW'(TICK_CYC - 1)) begin
			st_nxt.tick_cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + TCW'(1);
		end
		if (!st_r.started) begin
			st_nxt.started = 1'b1;
			st_nxt.delay_snap = clamp_delay(powerup_alarm_delay_param_in);
			st_nxt.hold_snap = startup_hold_param_in;
		end
		if (st_r.started && !st_r.delay_done && st_r.tick) begin
			if (st_r.delay_tenths >= st_r.delay_snap) begin
				st_nxt.delay_done = 1'b1;
			end else if (st_r.delay_ticks == DLW'(DELAY_TICKS_PER_TENTH - 1)) begin
				st_nxt.delay_ticks = '0;
				st_nxt.delay_tenths = st_r.delay_tenths + 14'h0001;
			end else begin
				st_nxt.delay_ticks = st_r.delay_ticks + DLW'(1);
			end
		end
		raw.ll = $signed(avg_mean) < $signed(setpoints_in.sp_ll);
		raw.l = $signed(avg_mean) < $signed(setpoints_in.sp_l);
		raw.h = $signed(avg_mean) > $signed(setpoints_in.sp_h);
		raw.hh = $signed(avg_mean) > $signed(setpoints_in.sp_hh);
		raw.pass = !raw.l && !raw.h;
		if (sample_in.overrange) begin
			raw = '0;
			raw.h = sample_in.over_high;
			raw.hh = sample_in.over_high;
			raw.l = !sample_in.over_high;
			raw.ll = !sample_in.over_high;
		end
		if (avg_done && raw.pass && !sample_in.overrange) begin
			st_nxt.standby_done = 1'b1;
		end
		if (latch_mode_param_in == LATCH_NONE || ext_reset_in) begin
			st_nxt.latched = '0;
		end
		if (avg_done) begin
			st_nxt.analog = avg_mean;
			if (!st_r.frozen) begin
				st_nxt.display = avg_mean;
			end
		end
		if (avg_done || sample_in.overrange) begin
			if (!st_r.delay_done || (st_r.hold_snap && !st_nxt.standby_done)) begin
				st_nxt.alarm = '0;
				st_nxt.indicator = '0;
			end else if (sample_in.overrange && !overrange_action_param_in) begin
				st_nxt.alarm = '0;
				st_nxt.indicator = '0;
			end else begin
				if (latch_mode_param_in != LATCH_NONE && !ext_reset_in) begin
					st_nxt.latched.ll = st_nxt.latched.ll | raw.ll;
					st_nxt.latched.l = st_nxt.latched.l | raw.l;
					st_nxt.latched.h = st_nxt.latched.h | raw.h;
					st_nxt.latched.hh = st_nxt.latched.hh | raw.hh;
				end
				st_nxt.latched.pass = 1'b0;
				st_nxt.alarm = raw | st_nxt.latched;
				st_nxt.indicator = raw;
			end
		end
		// freeze while latched in all mode
		st_nxt.frozen = (latch_mode_param_in == LATCH_ALL) && (|st_nxt.latched);
		// analog held inactive in standby
		// Off until the standby choice is captured, else it wakes for a cycle
		st_nxt.analog_en = st_r.started && !(st_r.hold_snap && !st_r.standby_done);
		if (st_r.menu == MENU_MEASURE) begin
			if (!(btn_down_in && btn_up_in)) begin
				st_nxt.hold_cnt = '0;
			end else if (st_r.tick) begin
				if (st_r.hold_cnt == 7'(HOLD_TICKS - 1)) begin
					st_nxt.menu = MENU_AVG_TYPE;
					st_nxt.hold_cnt = '0;
				end else begin
					st_nxt.hold_cnt = st_r.hold_cnt + 7'h01;
				end
			end
		end else if (btn_down_in && btn_up_in) begin
			st_nxt.menu = st_r.menu;
		end else if (down_edge) begin
			case (st_r.menu)
				MENU_AVG_TYPE: st_nxt.menu = MENU_PASS;
				MENU_PASS: st_nxt.menu = MENU_LATCH;
				MENU_LATCH: st_nxt.menu = MENU_POWERUP_ALARM_DELAY_PARAM;
				MENU_POWERUP_ALARM_DELAY_PARAM: st_nxt.menu = MENU_STARTUP_HOLD_PARAM;
				MENU_STARTUP_HOLD_PARAM: st_nxt.menu = MENU_OVR;
				MENU_OVR: st_nxt.menu = MENU_ROUND;
				default: st_nxt.menu = MENU_MEASURE;
			endcase
		end else if (up_edge) begin
			case (st_r.menu)
				MENU_ROUND: st_nxt.menu = MENU_OVR;
				MENU_OVR: st_nxt.menu = MENU_STARTUP_HOLD_PARAM;
				MENU_STARTUP_HOLD_PARAM: st_nxt.menu = MENU_POWERUP_ALARM_DELAY_PARAM;
				MENU_POWERUP_ALARM_DELAY_PARAM: st_nxt.menu = MENU_LATCH;
				MENU_LATCH: st_nxt.menu = MENU_PASS;
				MENU_PASS: st_nxt.menu = MENU_AVG_TYPE;
				default: st_nxt.menu = MENU_MEASURE;
			endcase
		end
		if (st_nxt.menu == MENU_POWERUP_ALARM_DELAY_PARAM && st_r.menu != MENU_POWERUP_ALARM_DELAY_PARAM) begin
			st_nxt.digit = 2'h3;
			st_nxt.delay_edit = clamp_delay(powerup_alarm_delay_param_in);
		end else if (st_r.menu == MENU_POWERUP_ALARM_DELAY_PARAM) begin
			if (shift_edge) begin
				st_nxt.digit = st_r.digit - 2'h1;
			end else if (digit_edge) begin
				// Digit wraps 9 to 0, so the value never passes 999.9
				if (dig_val == 4'h9) begin
					st_nxt.delay_edit = st_r.delay_edit - 14'(9 * step);
				end else begin
					st_nxt.delay_edit = st_r.delay_edit + step;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign alarm_out = st_r.alarm;
	assign indicator_out = st_r.indicator;
	assign display_out = st_r.display;
	assign analog_out = st_r.analog;
	assign analog_enable_out = st_r.analog_en;
	assign display_frozen_out = st_r.frozen;
	assign menu_out = st_r.menu;
	assign edit_digit_out = st_r.digit;
	assign delay_edit_out = st_r.delay_edit;
endmodule
`default_nettype wire

// ===== src/avg_engine.sv
`default_nettype none
module avg_engine #(
	parameter int W = alarm_avg_pkg::SAMPLE_W,
	parameter int DEPTH = alarm_avg_pkg::DEPTH_MAX
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic restart_in,
	input wire logic sample_in,
	input wire logic [W-1:0] value_in,
	input wire logic block_in,
	input wire logic [3:0] depth_log_in,
	output logic done_out,
	output logic [W-1:0] mean_out
);
	import alarm_avg_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int SW = W + AW + 1;
	logic [W-1:0] store [DEPTH];
	typedef struct packed {
		logic [SW-1:0] sum;
		logic [AW:0] count;
		logic [AW-1:0] wptr;
		logic done;
		logic [W-1:0] mean;
	} state_s;
	state_s st_r, st_nxt;
	logic [AW:0] target;
	logic [W-1:0] oldest;
	logic [SW-1:0] ns;
	logic [AW:0] nc;
	assign target = (AW+1)'(1) << depth_log_in;
	assign oldest = store[st_r.wptr - AW'(st_r.count)];
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		// Samples are signed, so every widening sign-extends
		ns = st_r.sum + SW'($signed(value_in));
		nc = st_r.count + (AW+1)'(1);
		if (restart_in) begin
			st_nxt.sum = '0;
			st_nxt.count = '0;
			st_nxt.wptr = '0;
		end else if (sample_in) begin
			st_nxt.wptr = st_r.wptr + AW'(1);
			st_nxt.done = (depth_log_in == 4'h0) || !block_in || (nc == target);
			if (depth_log_in == 4'h0) begin
				st_nxt.mean = value_in;
			end else if (block_in) begin
				if (nc == target) begin
					st_nxt.mean = W'($signed(ns) >>> depth_log_in);
					st_nxt.sum = '0;
					st_nxt.count = '0;
				end else begin
					st_nxt.sum = ns;
					st_nxt.count = nc;
				end
			end else if (st_r.count == target) begin
				st_nxt.sum = ns - SW'($signed(oldest));
				st_nxt.mean = W'($signed(st_nxt.sum) >>> depth_log_in);
			end else begin
				st_nxt.sum = ns;
				st_nxt.count = nc;
				st_nxt.mean = W'($signed(ns) / $signed(SW'(nc)));
			end
		end
	end
	always_ff @(posedge mclk_in) begin
		if (sample_in && !restart_in) begin
			store[st_r.wptr] <= value_in;
		end
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign done_out = st_r.done;
	assign mean_out = st_r.mean;
endmodule
`default_nettype wire
